/* design/amf_pkg.sv */
// amf_pkg: register indices, field positions, reset values, irq timing
// assumes a 50 MHz core clock; byte address of a register is 4 * index
package amf_pkg;
    localparam int CLK_HZ = 50_000_000;
    localparam int CLK_PER_US = CLK_HZ / 1_000_000;
    // irq pulse 3 ms, repeat period 4 ms
    localparam int IRQ_PULSE_US = 3000;
    localparam int IRQ_PERIOD_US = 4000;
    localparam int IRQ_PULSE_CYC = IRQ_PULSE_US * CLK_PER_US;
    localparam int IRQ_PERIOD_CYC = IRQ_PERIOD_US * CLK_PER_US;

    localparam int ADDR_W = 10;
    localparam int NUM_COND = 34;

    localparam logic [7:0] IDX_MASK_PROT = 8'h3B;
    localparam logic [7:0] IDX_MASK_DIAG = 8'h3C;
    localparam logic [7:0] IDX_MASK_CLK = 8'h3D;
    localparam logic [7:0] IDX_MASK_THERM = 8'h40;
    localparam logic [7:0] IDX_MASK_BO = 8'h41;
    localparam logic [7:0] IDX_LIVE_CLK = 8'h44;
    localparam logic [7:0] IDX_LIVE_THERM = 8'h47;
    localparam logic [7:0] IDX_LIVE_BO = 8'h48;
    localparam logic [7:0] IDX_LT_PROT = 8'h49;
    localparam logic [7:0] IDX_LT_DIAG = 8'h4A;
    localparam logic [7:0] IDX_LT_CLK = 8'h4B;
    localparam logic [7:0] IDX_LT_THERM = 8'h4F;
    localparam logic [7:0] IDX_TDM_TYPE = 8'h51;
    localparam logic [7:0] IDX_CTRL = 8'h5C;

    localparam logic [7:0] RST_MASK_PROT = 8'hFC;
    localparam logic [7:0] RST_MASK_DIAG = 8'hBF;
    localparam logic [7:0] RST_MASK_CLK = 8'hDF;
    localparam logic [7:0] RST_MASK_THERM = 8'hF6;
    localparam logic [7:0] RST_MASK_BO = 8'h00;
    localparam logic [4:0] RST_CTRL_HI = 5'h03;
    localparam logic [1:0] RST_PIN_CFG = 2'h1;

    localparam int BIT_PLL = 7;
    localparam int BIT_BAT = 5;
    localparam int BIT_TH2 = 7;
    localparam int BIT_TDM = 2;
    localparam int BIT_FUSE = 6;
    localparam int BIT_DONE = 5;
    localparam int BIT_RES_HI = 4;
    localparam int BIT_RES_LO = 3;
    localparam int BIT_GAIN = 0;
    localparam int BIT_CLR = 2;
    localparam int CTRL_HI_LO = 3;
    localparam logic [7:0] SHUT_THERM_MASK = 8'h0F;

    localparam logic [1:0] LOAD_OPEN = 2'h1;
    localparam logic [1:0] LOAD_SHORT = 2'h2;
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_DECODE = 2'h3;

    typedef enum logic [1:0] {
        AMF_IRQ_LIVE,
        AMF_IRQ_LATCHED,
        AMF_IRQ_PULSE_ONCE,
        AMF_IRQ_PULSE_REPEAT
    } amf_irq_mode_e;
endpackage

/* design/amf_sync3.sv */
// amf_sync3: three-flop synchroniser for asynchronous condition levels
// assumes inputs are slow levels; a change is taken once stages 2 and 3 agree
`timescale 1ns/10ps
`default_nettype none
module amf_sync3 #(
    parameter int W = 8
) (
    input wire logic clk,
    input wire logic reset_n,
    input wire logic ce,
    input wire logic [W-1:0] d,
    output logic [W-1:0] q
);
    typedef struct packed {
        logic [W-1:0] s1;
        logic [W-1:0] s2;
        logic [W-1:0] s3;
        logic [W-1:0] q;
    } amf_sync_s;

    amf_sync_s r_reg;
    amf_sync_s r_next;

    always_comb begin
        r_next = r_reg;
        r_next.s1 = d;
        r_next.s2 = r_reg.s1;
        r_next.s3 = r_reg.s2;
        // s1 is never looked at here: s2/s3 decide, and q holds while they differ
        r_next.q = (r_reg.s2 & r_reg.s3) | (r_reg.q & (r_reg.s2 | r_reg.s3));
    end

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            r_reg <= '0;
        end else if (ce) begin
            r_reg <= r_next;
        end
    end

    assign q = r_reg.q;
endmodule
`default_nettype wire

/* design/amf_pulse_timer.sv */
// amf_pulse_timer: irq pulse generator, one shot or repeating
// assumes trig is a one-cycle event and rpt a level from the same clock
`timescale 1ns/10ps
`default_nettype none
module amf_pulse_timer #(
    parameter int PULSE_CYC = amf_pkg::IRQ_PULSE_CYC,
    parameter int PERIOD_CYC = amf_pkg::IRQ_PERIOD_CYC
) (
    input wire logic clk,
    input wire logic reset_n,
    input wire logic ce,
    input wire logic trig,
    input wire logic rpt,
    output logic pulse
);
    localparam int CW = $clog2(PERIOD_CYC + 1);

    typedef struct packed {
        logic active;
        logic [CW-1:0] cnt;
    } amf_tmr_s;

    amf_tmr_s r_reg;
    amf_tmr_s r_next;

    always_comb begin
        r_next = r_reg;
        if (!r_reg.active) begin
            if (trig || rpt) begin
                r_next.active = 1'b1;
                r_next.cnt = '0;
            end
        end else if (r_reg.cnt == CW'(PERIOD_CYC - 1)) begin
            // events inside a running period are absorbed by it
            r_next.active = rpt;
            r_next.cnt = '0;
        end else begin
            r_next.cnt = r_reg.cnt + 1'b1;
        end
    end

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            r_reg <= '0;
        end else if (ce) begin
            r_reg <= r_next;
        end
    end

    assign pulse = r_reg.active && (r_reg.cnt < CW'(PULSE_CYC));
endmodule
`default_nettype wire

/* design/amf_status_top.sv */
// amf_status_top: live and latched fault flags, masks, irq pin, Avalon-MM slave
// assumes condition inputs are asynchronous levels; bus is on CLK
//
// The Avalon-MM interface to the registers is this design's own decision.
`timescale 1ns/10ps
`default_nettype none
module amf_status_top #(
    parameter int PULSE_CYC = amf_pkg::IRQ_PULSE_CYC,
    parameter int PERIOD_CYC = amf_pkg::IRQ_PERIOD_CYC
) (
    input wire logic CLK,
    input wire logic RESET_N,
    input wire logic CE,
    input wire logic [amf_pkg::ADDR_W-1:0] ADDRESS,
    input wire logic READ,
    input wire logic WRITE,
    input wire logic [31:0] WRITEDATA,
    input wire logic [3:0] BYTEENABLE,
    output logic [31:0] READDATA,
    output logic [1:0] RESPONSE,
    output logic WAITREQUEST,
    input wire logic PLL_CLOCK_FAULT,
    input wire logic BATTERY_UNDERVOLTAGE,
    input wire logic [7:0] THERMAL_REGULATOR,
    input wire logic [7:0] BROWNOUT,
    input wire logic [7:0] PROTECTION_EVENTS,
    input wire logic FUSE_CHECKSUM_ERROR,
    input wire logic LOAD_DIAG_DONE,
    input wire logic [1:0] LOAD_DIAG_RESULT,
    input wire logic GAIN_LIMITER,
    input wire logic [2:0] FRAME_CLOCK_ERROR_TYPE,
    output logic SHUTDOWN,
    output logic IRQ_N
);
    typedef amf_pkg::amf_irq_mode_e amf_irq_mode_e;

    typedef struct packed {
        logic [7:0] lt_prot;
        logic [7:0] lt_diag;
        logic [7:0] lt_clk;
        logic [7:0] lt_therm;
        logic [2:0] tdm_type;
        logic [7:0] mask_prot;
        logic [7:0] mask_diag;
        logic [7:0] mask_clk;
        logic [7:0] mask_therm;
        logic [7:0] mask_bo;
        logic [4:0] ctrl_hi;
        logic clr;
        logic [1:0] pin_cfg;
        logic ack;
        logic [7:0] rdata;
        logic [1:0] resp;
        logic [23:0] live_prev;
        logic irq;
        logic shutdown;
    } amf_state_s;

    localparam amf_state_s RST_STATE = '{
        mask_prot: amf_pkg::RST_MASK_PROT,
        mask_diag: amf_pkg::RST_MASK_DIAG,
        mask_clk: amf_pkg::RST_MASK_CLK,
        mask_therm: amf_pkg::RST_MASK_THERM,
        mask_bo: amf_pkg::RST_MASK_BO,
        ctrl_hi: amf_pkg::RST_CTRL_HI,
        pin_cfg: amf_pkg::RST_PIN_CFG,
        default: '0
    };

    amf_state_s r_reg;
    amf_state_s r_next;

    logic [amf_pkg::NUM_COND-1:0] cond_sync;
    logic pll_s;
    logic bat_s;
    logic [7:0] live_therm;
    logic [7:0] live_bo;
    logic [7:0] ev_prot;
    logic fuse_s;
    logic done_s;
    logic [1:0] res_s;
    logic gain_s;
    logic [2:0] type_s;
    logic [7:0] live_clk;
    logic [23:0] live_unm;
    logic live_any;
    logic live_event;
    logic [1:0] lt_res;
    logic diag_unm;
    logic lt_any;
    logic pulse;
    logic tmr_trig;
    logic tmr_rpt;
    amf_irq_mode_e mode;
    logic req;
    logic first;
    logic commit;
    logic aligned;
    logic [7:0] idx;
    logic [7:0] rd_mux;
    logic hit;

    // fault sources come from analog blocks, not from CLK
    amf_sync3 #(
        .W(amf_pkg::NUM_COND)
    ) u_sync (
        .clk(CLK),
        .reset_n(RESET_N),
        .ce(CE),
        .d({PLL_CLOCK_FAULT, BATTERY_UNDERVOLTAGE, THERMAL_REGULATOR, BROWNOUT,
            PROTECTION_EVENTS, FUSE_CHECKSUM_ERROR, LOAD_DIAG_DONE, LOAD_DIAG_RESULT,
            GAIN_LIMITER, FRAME_CLOCK_ERROR_TYPE}),
        .q(cond_sync)
    );

    assign {pll_s, bat_s, live_therm, live_bo, ev_prot, fuse_s, done_s, res_s, gain_s,
            type_s} = cond_sync;

    amf_pulse_timer #(
        .PULSE_CYC(PULSE_CYC),
        .PERIOD_CYC(PERIOD_CYC)
    ) u_tmr (
        .clk(CLK),
        .reset_n(RESET_N),
        .ce(CE),
        .trig(tmr_trig),
        .rpt(tmr_rpt),
        .pulse(pulse)
    );

    assign live_clk = (8'(pll_s) << amf_pkg::BIT_PLL) | (8'(bat_s) << amf_pkg::BIT_BAT);
    assign live_unm = {live_clk & ~r_reg.mask_clk, live_therm & ~r_reg.mask_therm,
                       live_bo & ~r_reg.mask_bo};
    assign live_any = |live_unm;
    assign live_event = |(live_unm & ~r_reg.live_prev);
    assign lt_res = r_reg.lt_diag[amf_pkg::BIT_RES_HI:amf_pkg::BIT_RES_LO];
    assign diag_unm = (r_reg.lt_diag[amf_pkg::BIT_FUSE] & ~r_reg.mask_diag[amf_pkg::BIT_FUSE])
        | (r_reg.lt_diag[amf_pkg::BIT_DONE] & ~r_reg.mask_diag[amf_pkg::BIT_DONE])
        | ((lt_res == amf_pkg::LOAD_OPEN) & ~r_reg.mask_diag[amf_pkg::BIT_RES_LO])
        | ((lt_res == amf_pkg::LOAD_SHORT) & ~r_reg.mask_diag[amf_pkg::BIT_RES_HI])
        | (r_reg.lt_diag[amf_pkg::BIT_GAIN] & ~r_reg.mask_diag[amf_pkg::BIT_GAIN]);
    assign lt_any = diag_unm | |(r_reg.lt_prot & ~r_reg.mask_prot)
        | |(r_reg.lt_clk & ~r_reg.mask_clk) | |(r_reg.lt_therm & ~r_reg.mask_therm);
    assign mode = amf_irq_mode_e'(r_reg.pin_cfg);
    assign tmr_trig = (mode == amf_pkg::AMF_IRQ_PULSE_ONCE) && live_event;
    assign tmr_rpt = (mode == amf_pkg::AMF_IRQ_PULSE_REPEAT) && lt_any;

    // one wait state: request seen, answer on the next edge
    assign req = READ || WRITE;
    assign first = req && !r_reg.ack;
    assign commit = req && r_reg.ack;
    assign aligned = (ADDRESS[1:0] == 2'h0);
    assign idx = ADDRESS[amf_pkg::ADDR_W-1:2];

    always_comb begin
        rd_mux = 8'h00;
        hit = aligned;
        unique case (idx)
            amf_pkg::IDX_MASK_PROT: rd_mux = r_reg.mask_prot;
            amf_pkg::IDX_MASK_DIAG: rd_mux = r_reg.mask_diag;
            amf_pkg::IDX_MASK_CLK: rd_mux = r_reg.mask_clk;
            amf_pkg::IDX_MASK_THERM: rd_mux = r_reg.mask_therm;
            amf_pkg::IDX_MASK_BO: rd_mux = r_reg.mask_bo;
            amf_pkg::IDX_LIVE_CLK: rd_mux = live_clk;
            amf_pkg::IDX_LIVE_THERM: rd_mux = live_therm;
            amf_pkg::IDX_LIVE_BO: rd_mux = live_bo;
            amf_pkg::IDX_LT_PROT: rd_mux = r_reg.lt_prot;
            amf_pkg::IDX_LT_DIAG: rd_mux = r_reg.lt_diag;
            amf_pkg::IDX_LT_CLK: rd_mux = r_reg.lt_clk;
            amf_pkg::IDX_LT_THERM: rd_mux = r_reg.lt_therm;
            amf_pkg::IDX_TDM_TYPE: rd_mux = {5'h00, r_reg.tdm_type};
            amf_pkg::IDX_CTRL: rd_mux = {r_reg.ctrl_hi, r_reg.clr, r_reg.pin_cfg};
            default: hit = 1'b0;
        endcase
        if (!aligned) begin
            rd_mux = 8'h00;
        end
    end

    always_comb begin
        r_next = r_reg;
        r_next.ack = first;
        if (first) begin
            r_next.rdata = rd_mux;
            r_next.resp = hit ? amf_pkg::RESP_OKAY : amf_pkg::RESP_DECODE;
        end
        // latches: set wins over a clear in the same cycle
        r_next.clr = 1'b0;
        if (r_reg.clr) begin
            r_next.lt_prot = '0;
            r_next.lt_diag = '0;
            r_next.lt_clk = '0;
            r_next.lt_therm = '0;
            r_next.tdm_type = '0;
        end
        r_next.lt_prot = r_next.lt_prot | ev_prot;
        r_next.lt_clk = r_next.lt_clk | live_clk;
        r_next.lt_therm = r_next.lt_therm | live_therm;
        if (ev_prot[amf_pkg::BIT_TDM]) begin
            r_next.tdm_type = r_next.tdm_type | type_s;
        end
        r_next.lt_diag[amf_pkg::BIT_FUSE] = r_next.lt_diag[amf_pkg::BIT_FUSE] | fuse_s;
        r_next.lt_diag[amf_pkg::BIT_DONE] = r_next.lt_diag[amf_pkg::BIT_DONE] | done_s;
        r_next.lt_diag[amf_pkg::BIT_GAIN] = r_next.lt_diag[amf_pkg::BIT_GAIN] | gain_s;
        // result only means something at completion
        if (done_s) begin
            r_next.lt_diag[amf_pkg::BIT_RES_HI:amf_pkg::BIT_RES_LO] = res_s;
        end
        if (commit && WRITE && aligned && BYTEENABLE[0]) begin
            unique case (idx)
                amf_pkg::IDX_MASK_PROT: r_next.mask_prot = WRITEDATA[7:0];
                amf_pkg::IDX_MASK_DIAG: r_next.mask_diag = WRITEDATA[7:0];
                amf_pkg::IDX_MASK_CLK: r_next.mask_clk = WRITEDATA[7:0];
                amf_pkg::IDX_MASK_THERM: r_next.mask_therm = WRITEDATA[7:0];
                amf_pkg::IDX_MASK_BO: r_next.mask_bo = WRITEDATA[7:0];
                amf_pkg::IDX_CTRL: begin
                    r_next.ctrl_hi = WRITEDATA[7:amf_pkg::CTRL_HI_LO];
                    r_next.clr = WRITEDATA[amf_pkg::BIT_CLR];
                    r_next.pin_cfg = WRITEDATA[1:0];
                end
                default: r_next.ctrl_hi = r_reg.ctrl_hi;
            endcase
        end
        r_next.live_prev = live_unm;
        unique case (mode)
            amf_pkg::AMF_IRQ_LIVE: r_next.irq = live_any;
            amf_pkg::AMF_IRQ_LATCHED: r_next.irq = lt_any;
            amf_pkg::AMF_IRQ_PULSE_ONCE: r_next.irq = pulse;
            amf_pkg::AMF_IRQ_PULSE_REPEAT: r_next.irq = pulse;
        endcase
        r_next.shutdown = pll_s || bat_s || |(live_therm & amf_pkg::SHUT_THERM_MASK)
            || live_bo[amf_pkg::BIT_TH2];
    end

    always_ff @(posedge CLK or negedge RESET_N) begin
        if (!RESET_N) begin
            r_reg <= RST_STATE;
        end else if (CE) begin
            r_reg <= r_next;
        end
    end

    assign WAITREQUEST = first;
    assign READDATA = {24'h000000, r_reg.rdata};
    assign RESPONSE = r_reg.resp;
    assign SHUTDOWN = r_reg.shutdown;
    assign IRQ_N = !r_reg.irq;

    default clocking cb @(posedge CLK);
    endclocking
    default disable iff (!RESET_N);

    AST_CLR_SELF: assert property (CE && r_reg.clr |=> !r_reg.clr)
        else $error("latch clear did not self clear");
    AST_CLR_WIPES: assert property (CE && r_reg.clr && ev_prot == 8'h00
        |=> r_reg.lt_prot == 8'h00)
        else $error("latched protection events survived a clear");
    AST_HOLD: assert property (CE && !r_reg.clr
        |=> (r_reg.lt_therm & $past(r_reg.lt_therm)) == $past(r_reg.lt_therm))
        else $error("latched flag dropped without a clear");
    AST_PROT_SET: assert property (CE
        |=> (r_reg.lt_prot & $past(ev_prot)) == $past(ev_prot))
        else $error("protection event not latched");
    AST_CLK_RSVD: assert property (CE && pll_s
        |=> r_reg.lt_clk[amf_pkg::BIT_PLL] && r_reg.lt_clk[4:0] == 5'h00)
        else $error("clock fault latch wrong");
    AST_THERM_SET: assert property (CE && !r_reg.clr
        |=> (r_reg.lt_therm & $past(live_therm)) == $past(live_therm))
        else $error("thermal event not latched");
    AST_TDM_TYPE: assert property (CE && ev_prot[amf_pkg::BIT_TDM]
        |=> (r_reg.tdm_type & $past(type_s)) == $past(type_s))
        else $error("frame clock error type not recorded");
    AST_DIAG_RES: assert property (CE && done_s
        |=> r_reg.lt_diag[amf_pkg::BIT_RES_HI:amf_pkg::BIT_RES_LO] == $past(res_s))
        else $error("load result not captured");
    AST_DIAG_DONE: assert property (CE && done_s && fuse_s
        |=> r_reg.lt_diag[amf_pkg::BIT_DONE] && r_reg.lt_diag[amf_pkg::BIT_FUSE])
        else $error("diagnostic latch not set");
    AST_LIVE_RD: assert property (CE && first && aligned && idx == amf_pkg::IDX_LIVE_THERM
        |=> READDATA[7:0] == $past(live_therm))
        else $error("thermal live read mismatch");
    AST_BO_RD: assert property (CE && first && aligned && idx == amf_pkg::IDX_LIVE_BO
        |=> READDATA[7:0] == $past(live_bo))
        else $error("brownout live read mismatch");
    AST_SHUT: assert property (CE && (live_therm[0] || live_bo[amf_pkg::BIT_TH2])
        |=> SHUTDOWN)
        else $error("shutdown not flagged");
    AST_PLL_SHUT: assert property (CE && pll_s |=> SHUTDOWN)
        else $error("pll fault did not flag shutdown");
    AST_IRQ_LIVE: assert property (CE && mode == amf_pkg::AMF_IRQ_LIVE
        |=> IRQ_N == !$past(live_any))
        else $error("irq pin does not follow unmasked live flags");
    AST_MASKED: assert property (CE && mode == amf_pkg::AMF_IRQ_LIVE
        && r_reg.mask_bo == 8'hFF && r_reg.mask_clk == 8'hFF && r_reg.mask_therm == 8'hFF
        |=> IRQ_N)
        else $error("masked source reached the irq pin");
    AST_REG_SHUT: assert property (CE && (live_therm & amf_pkg::SHUT_THERM_MASK) != 8'h00
        |=> SHUTDOWN)
        else $error("regulator fault did not flag shutdown");
    AST_NO_SHUT: assert property (CE && !pll_s && !bat_s && !live_bo[amf_pkg::BIT_TH2]
        && (live_therm & amf_pkg::SHUT_THERM_MASK) == 8'h00 |=> !SHUTDOWN)
        else $error("shutdown flagged with no shutdown cause");

    COV_CLEAR: cover property (CE && r_reg.clr && r_reg.lt_prot != 8'h00);
    COV_REPEAT: cover property (mode == amf_pkg::AMF_IRQ_PULSE_REPEAT && !IRQ_N);
    COV_WRITE: cover property (commit && WRITE && idx == amf_pkg::IDX_CTRL);
    COV_SHORT: cover property (done_s && res_s == amf_pkg::LOAD_SHORT);
endmodule
`default_nettype wire

/* sim/amf_host_model.sv */
// amf_host_model: avalon-mm master in the place of the host controller
// assumes one request at a time; only the bench timeout ends a hung wait
`timescale 1ns/10ps
`default_nettype none
module amf_host_model (
    input wire logic clk,
    input wire logic [31:0] readdata,
    input wire logic [1:0] response,
    input wire logic waitrequest,
    output logic [9:0] address,
    output logic read,
    output logic write,
    output logic [31:0] writedata,
    output logic [3:0] byteenable
);
    initial begin
        address = 10'h000;
        read = 1'b0;
        write = 1'b0;
        writedata = 32'h00000000;
        byteenable = 4'h1;
    end
    // request stands until the rising edge that sees waitrequest low
    task automatic xfer(input logic rnw, input logic [7:0] idx, input logic [7:0] wd,
                        output logic [31:0] rdat, output logic [1:0] rsp);
        @(posedge clk);
        address <= {idx, 2'h0};
        read <= rnw;
        write <= !rnw;
        writedata <= {24'h000000, wd};
        do begin
            @(posedge clk);
        end while (waitrequest !== 1'b0);
        rdat = readdata;
        rsp = response;
        read <= 1'b0;
        write <= 1'b0;
    endtask
endmodule
`default_nettype wire

/* sim/tb_top.sv */
// tb_top: self-checking bench for the fault status block
// assumes the host model drives the bus and short irq pulse counts
`timescale 1ns/10ps
`default_nettype none
module tb_top;
    localparam int PULSE = 5;
    localparam int PERIOD = 10;
    logic clk, reset_n, ce, pll, bat, fuse, done, gain, shutdown, irq_n, rd, wr_s, wait_s;
    logic [7:0] therm, bo, prot;
    logic [1:0] res, rsp, resp_s;
    logic [2:0] ftype;
    logic [9:0] addr;
    logic [31:0] wdata, rdata, rdat;
    logic [3:0] be;
    int fail_count, total_checks, cyc, c;
    amf_host_model host (.clk(clk), .readdata(rdata), .response(resp_s),
        .waitrequest(wait_s), .address(addr), .read(rd), .write(wr_s),
        .writedata(wdata), .byteenable(be));
    amf_status_top #(.PULSE_CYC(PULSE), .PERIOD_CYC(PERIOD)) dut (.CLK(clk),
        .RESET_N(reset_n), .CE(ce), .ADDRESS(addr), .READ(rd), .WRITE(wr_s),
        .WRITEDATA(wdata), .BYTEENABLE(be), .READDATA(rdata), .RESPONSE(resp_s),
        .WAITREQUEST(wait_s), .PLL_CLOCK_FAULT(pll), .BATTERY_UNDERVOLTAGE(bat),
        .THERMAL_REGULATOR(therm), .BROWNOUT(bo), .PROTECTION_EVENTS(prot),
        .FUSE_CHECKSUM_ERROR(fuse), .LOAD_DIAG_DONE(done), .LOAD_DIAG_RESULT(res),
        .GAIN_LIMITER(gain), .FRAME_CLOCK_ERROR_TYPE(ftype), .SHUTDOWN(shutdown),
        .IRQ_N(irq_n));
    initial begin
        clk = 1'b0;
        forever #10 clk = ~clk;
    end
    task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
        total_checks++;
        if (got !== exp) begin
            fail_count++;
            $display("Error %s expected %h seen %h", nm, exp, got);
        end
    endtask
    task automatic rdchk(input logic [7:0] idx, input logic [7:0] exp);
        host.xfer(1'b1, idx, 8'h00, rdat, rsp);
        chk($sformatf("reg %h", idx), {24'h000000, exp}, rdat);
        chk($sformatf("resp %h", idx), 32'h0, {30'h0, rsp});
    endtask
    task automatic wr(input logic [7:0] idx, input logic [7:0] d);
        host.xfer(1'b0, idx, d, rdat, rsp);
    endtask
    task automatic wt(input int n);
        repeat (n) @(posedge clk);
    endtask
    task automatic cnt_low(input int n);
        c = 0;
        repeat (n) begin
            @(negedge clk);
            if (irq_n === 1'b0) c++;
        end
        @(posedge clk);
    endtask
    task automatic t_reset();
        logic [7:0] idx [7] = '{8'h44, 8'h47, 8'h48, 8'h49, 8'h4A, 8'h4B, 8'h4F};
        logic [7:0] msk [5] = '{8'h3B, 8'h3C, 8'h3D, 8'h40, 8'h41};
        logic [7:0] mrst [5] = '{8'hFC, 8'hBF, 8'hDF, 8'hF6, 8'h00};
        foreach (idx[i]) rdchk(idx[i], 8'h00);
        foreach (msk[i]) rdchk(msk[i], mrst[i]);
        wr(8'h44, 8'hFF);
        rdchk(8'h44, 8'h00);
        host.xfer(1'b1, 8'h60, 8'h00, rdat, rsp);
        chk("unmapped data", 32'h0, rdat);
        chk("unmapped resp", 32'h3, {30'h0, rsp});
        $display("test reset done");
    endtask
    task automatic t_live();
        pll <= 1'b1;
        bat <= 1'b1;
        therm <= 8'hA5;
        bo <= 8'h3C;
        wt(10);
        rdchk(8'h44, 8'hA0);
        rdchk(8'h47, 8'hA5);
        rdchk(8'h48, 8'h3C);
        chk("shutdown", 32'h1, {31'h0, shutdown});
        chk("irq latched", 32'h0, {31'h0, irq_n});
        pll <= 1'b0;
        bat <= 1'b0;
        therm <= 8'h00;
        bo <= 8'h40;
        wt(10);
        rdchk(8'h44, 8'h00);
        rdchk(8'h48, 8'h40);
        chk("shutdown thr one", 32'h0, {31'h0, shutdown});
        bo <= 8'h80;
        wt(10);
        chk("shutdown thr two", 32'h1, {31'h0, shutdown});
        bo <= 8'h00;
        wt(10);
        rdchk(8'h4B, 8'hA0);
        rdchk(8'h4F, 8'hA5);
        $display("test live done");
    endtask
    task automatic t_events();
        prot <= 8'hFF;
        ftype <= 3'h5;
        fuse <= 1'b1;
        done <= 1'b1;
        res <= 2'h2;
        gain <= 1'b1;
        wt(10);
        prot <= 8'h00;
        fuse <= 1'b0;
        done <= 1'b0;
        gain <= 1'b0;
        wt(10);
        rdchk(8'h49, 8'hFF);
        rdchk(8'h4A, 8'h71);
        rdchk(8'h51, 8'h05);
        done <= 1'b1;
        res <= 2'h1;
        wt(10);
        done <= 1'b0;
        wt(10);
        rdchk(8'h4A, 8'h69);
        $display("test events done");
    endtask
    task automatic t_clear();
        logic [7:0] idx [5] = '{8'h49, 8'h4A, 8'h4B, 8'h4F, 8'h51};
        wr(8'h5C, 8'h1D);
        rdchk(8'h5C, 8'h19);
        foreach (idx[i]) rdchk(idx[i], 8'h00);
        chk("irq cleared", 32'h1, {31'h0, irq_n});
        wr(8'h3D, 8'hFF);
        bat <= 1'b1;
        wt(10);
        bat <= 1'b0;
        chk("irq masked", 32'h1, {31'h0, irq_n});
        rdchk(8'h4B, 8'h20);
        wr(8'h3D, 8'hDF);
        wt(3);
        chk("irq unmasked", 32'h0, {31'h0, irq_n});
        $display("test clear done");
    endtask
    task automatic t_modes();
        wr(8'h5C, 8'h18);
        bat <= 1'b1;
        wt(10);
        chk("irq live on", 32'h0, {31'h0, irq_n});
        bat <= 1'b0;
        wt(10);
        chk("irq live off", 32'h1, {31'h0, irq_n});
        wr(8'h5C, 8'h1A);
        bat <= 1'b1;
        cnt_low(30);
        chk("one shot", PULSE, c);
        bat <= 1'b0;
        wr(8'h5C, 8'h1B);
        cnt_low(40);
        chk("repeat", 4 * PULSE, c);
        $display("test modes done");
    endtask
    task automatic t_freeze();
        ce <= 1'b0;
        bat <= 1'b1;
        wt(10);
        chk("frozen shutdown", 32'h0, {31'h0, shutdown});
        ce <= 1'b1;
        wt(10);
        chk("thawed shutdown", 32'h1, {31'h0, shutdown});
        bat <= 1'b0;
        $display("test freeze done");
    endtask
    task automatic report_and_stop();
        $display("checks %0d mismatches %0d", total_checks, fail_count);
        if (fail_count == 0 && total_checks > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask
    always @(posedge clk) begin
        cyc++;
        if (cyc == 4000) begin
            fail_count++;
            report_and_stop();
        end
    end
    initial begin
        {pll, bat, fuse, done, gain, therm, bo, prot, res, ftype} = '0;
        ce = 1'b1;
        fail_count = 0;
        total_checks = 0;
        cyc = 0;
        reset_n = 1'b0;
        wt(20);
        reset_n <= 1'b1;
        t_reset();
        t_live();
        t_events();
        t_clear();
        t_modes();
        t_freeze();
        report_and_stop();
    end
endmodule
`default_nettype wire
